// *** design/pad_mode_pkg.sv ***
// Package: constants, carrier structs and state for the host pad mode selector
//
// Operation
// RULE1 - Select high: SPI idle, I2C/I3C enabled
// RULE2 - Select pull-up off only when both disabled
// RULE3 - Second interrupt pin drives ground after reset
// RULE4 - Standard mode: interrupt output or data enable
// RULE5 - Hub mode adds master sync input role
// RULE6 - Serial clock shared, input without pull-up
// RULE7 - Serial data: I2C/I3C, SPI in, 3-wire out
// RULE8 - Host holds first interrupt pin low at power-on
// RULE9 - Data-out pin pull-up follows its enable bit
// RULE10 - First interrupt pull-down unless disable bit set
// RULE11 - Hub pins pull-ups follow hub enable bit
// RULE12 - Pull enables follow control bits combinationally
package pad_mode_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Reset values and sizes
    localparam int unsigned PAD_SYNC_WIDTH  = 6;     // Synchronised pad inputs
    localparam logic        PAD_OUT_RESET   = 1'h0;  // Pad outputs low after reset
    localparam logic        PAD_OE_RESET    = 1'h0;  // Pads released after reset
    localparam logic        IRQ_B_OE_RESET  = 1'h1;  // Second irq pin driven after reset
    localparam logic        SPI_MODE_RESET  = 1'h0;  // Select assumed high (pulled up)

    ////////////////////////////////////////////////////////////////////////////
    // Second interrupt pin roles
    typedef enum logic [1:0] {
        IRQ_B_GROUND   = 2'b00,  // Output forced to ground
        IRQ_B_OUTPUT   = 2'b01,  // Programmable interrupt output
        IRQ_B_DATA_EN  = 2'b10,  // Data enable input
        IRQ_B_HUB_SYNC = 2'b11   // Aux master sync input, hub mode only
    } irq_b_role_e;

    localparam irq_b_role_e IRQ_B_ROLE_RESET = IRQ_B_GROUND;

    ////////////////////////////////////////////////////////////////////////////
    // Carriers
    typedef struct packed {
        logic select_pullup;   // Interface select pad pull-up
        logic dout_pullup;     // Data-out / address LSB pad pull-up
        logic irq_a_pulldown;  // First interrupt pad pull-down
        logic hub_pullup;      // Aux master data and clock pad pull-ups
    } pad_pull_s;

    typedef struct packed {
        logic irq_b;     // Second interrupt pad
        logic irq_a;     // First interrupt pad
        logic addr_lsb;  // Data-out / address LSB pad
        logic sda;       // Serial data pad
        logic scl;       // Serial clock pad
        logic select;    // Interface select pad
    } pad_in_s;

    typedef struct packed {
        logic out;  // Level driven
        logic oe;   // High while driving
    } pad_drive_s;

    typedef struct packed {
        irq_b_role_e role;      // Active second irq pin role
        logic        spi_mode;  // SPI selected
        pad_drive_s  sda;       // Serial data pad drive
        pad_drive_s  dout;      // Data-out pad drive
        pad_drive_s  irq_b;     // Second irq pad drive
    } pad_state_s;

endpackage : pad_mode_pkg

// *** design/pad_sync.sv ***
// Two-flop synchroniser for pad inputs
module pad_sync #(
    parameter int unsigned WIDTH = 1  // Number of pads
) (
    // Clock and reset
    input  wire logic             clk_sys_i,
    input  wire logic             resetn_i,
    // Pads in, synchronised out
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);

    ////////////////////////////////////////////////////////////////////////////
    // State: first and second stage
    typedef struct packed {
        logic [WIDTH-1:0] stage1;  // Only read by stage2
        logic [WIDTH-1:0] stage2;  // Safe to use
    } sync_state_s;

    sync_state_s state;       // Registered
    sync_state_s next_state;  // Next value

    // Shift pads through both stages
    always_comb begin
        next_state.stage1 = async_i;
        next_state.stage2 = state.stage1;
    end

    // Register stages
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign sync_o = state.stage2;

endmodule : pad_sync

// *** design/host_pad_mode.sv ***
// Host and auxiliary pad mode selection and default pad configuration
module host_pad_mode
    import pad_mode_pkg::*;
(
    // Clock and reset
    input  wire logic                      clk_sys_i,
    input  wire logic                      resetn_i,
    // Interface select and serial pads
    input  wire logic                      select_pin_i,
    input  wire logic                      scl_pin_i,
    input  wire logic                      sda_pin_i,
    output logic                           sda_pin_o,
    output logic                           sda_pin_oe_o,
    input  wire logic                      addr_lsb_pin_i,
    output logic                           addr_lsb_pin_o,
    output logic                           addr_lsb_pin_oe_o,
    // Interrupt pads
    input  wire logic                      irq_pin_a_i,
    input  wire logic                      irq_pin_b_i,
    output logic                           irq_pin_b_o,
    output logic                           irq_pin_b_oe_o,
    // Pad pull controls
    output pad_mode_pkg::pad_pull_s        pad_pull_o,
    // Configuration bits
    input  wire logic                      i2c_off_i,
    input  wire logic                      i3c_off_i,
    input  wire logic                      dout_pullup_on_i,
    input  wire logic                      irq_a_pulldown_off_i,
    input  wire logic                      hub_pullup_on_i,
    input  wire logic                      hub_mode_i,
    input  wire logic                      spi_three_wire_i,
    input  wire pad_mode_pkg::irq_b_role_e irq_b_role_i,
    // From protocol cores
    input  wire logic                      irq_b_level_i,
    input  wire logic                      spi_dout_i,
    input  wire logic                      spi_dout_en_i,
    input  wire logic                      i2c_sda_low_i,
    // To protocol cores
    output logic                           spi_active_o,
    output logic                           i2c_active_o,
    output logic                           i3c_active_o,
    output logic                           serial_clock_o,
    output logic                           serial_data_o,
    output logic                           addr_lsb_o,
    output logic                           irq_a_o,
    output logic                           data_enable_in_o,
    output logic                           hub_master_sync_in_o
);

    import pad_mode_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Pad synchronisers
    pad_in_s    pad_async;   // Raw pad levels
    pad_in_s    pad_sync_q;  // After two flops
    pad_state_s state;       // Registered state
    pad_state_s next_state;  // Next state

    // Gather raw pads
    always_comb begin
        pad_async.irq_b    = irq_pin_b_i;
        pad_async.irq_a    = irq_pin_a_i;
        pad_async.addr_lsb = addr_lsb_pin_i;
        pad_async.sda      = sda_pin_i;
        pad_async.scl      = scl_pin_i;
        // Select travels inverted, so a cleared stage reads as pulled-up high
        pad_async.select   = !select_pin_i;
    end

    pad_sync #(
        .WIDTH     (PAD_SYNC_WIDTH)
    ) u_pad_sync (
        .clk_sys_i (clk_sys_i),
        .resetn_i  (resetn_i),
        .async_i   (pad_async),
        .sync_o    (pad_sync_q)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Pull controls, combinational from control bits
    always_comb begin
        pad_pull_o.select_pullup  = !(i2c_off_i && i3c_off_i);  // RULE2 RULE12
        pad_pull_o.dout_pullup    = dout_pullup_on_i;           // RULE9 RULE12
        pad_pull_o.irq_a_pulldown = !irq_a_pulldown_off_i;      // RULE10 RULE12
        pad_pull_o.hub_pullup     = hub_pullup_on_i;            // RULE11 RULE12
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next state: mode decode, role and pad drives
    always_comb begin
        next_state = state;
        // Select low picks SPI; no false SPI pulse after reset
        next_state.spi_mode = pad_sync_q.select;  // RULE1
        // Role; hub sync only legal in hub mode
        if (irq_b_role_i == IRQ_B_HUB_SYNC && !hub_mode_i) begin
            next_state.role = IRQ_B_GROUND;  // RULE5
        end else begin
            next_state.role = irq_b_role_i;  // RULE4 RULE5
        end
        // Serial data pad
        if (next_state.spi_mode && spi_three_wire_i) begin
            next_state.sda.out = spi_dout_i;  // RULE7
            next_state.sda.oe  = spi_dout_en_i;
        end else if (!next_state.spi_mode) begin
            next_state.sda.out = 1'h0;  // RULE7
            next_state.sda.oe  = i2c_sda_low_i;
        end else begin
            next_state.sda.out = 1'h0;  // RULE7
            next_state.sda.oe  = 1'h0;
        end
        // Four-wire SPI data-out pad
        if (next_state.spi_mode && !spi_three_wire_i) begin
            next_state.dout.out = spi_dout_i;
            next_state.dout.oe  = spi_dout_en_i;
        end else begin
            next_state.dout.out = 1'h0;
            next_state.dout.oe  = 1'h0;
        end
        // Second interrupt pad drive per role
        case (next_state.role)
            IRQ_B_GROUND: begin
                next_state.irq_b.out = 1'h0;  // RULE3
                next_state.irq_b.oe  = 1'h1;
            end
            IRQ_B_OUTPUT: begin
                next_state.irq_b.out = irq_b_level_i;  // RULE4
                next_state.irq_b.oe  = 1'h1;
            end
            IRQ_B_DATA_EN, IRQ_B_HUB_SYNC: begin
                next_state.irq_b.out = 1'h0;  // RULE4 RULE5
                next_state.irq_b.oe  = 1'h0;
            end
            default: begin
                next_state.irq_b.out = 1'h0;
                next_state.irq_b.oe  = 1'h1;
            end
        endcase
    end

    // Register state; irq pad grounded from reset
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state.role      <= IRQ_B_ROLE_RESET;  // RULE3
            state.spi_mode  <= SPI_MODE_RESET;
            state.sda.out   <= PAD_OUT_RESET;
            state.sda.oe    <= PAD_OE_RESET;
            state.dout.out  <= PAD_OUT_RESET;
            state.dout.oe   <= PAD_OE_RESET;
            state.irq_b.out <= PAD_OUT_RESET;
            state.irq_b.oe  <= IRQ_B_OE_RESET;    // RULE3
        end else begin
            state <= next_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    assign sda_pin_o         = state.sda.out;
    assign sda_pin_oe_o      = state.sda.oe;
    assign addr_lsb_pin_o    = state.dout.out;
    assign addr_lsb_pin_oe_o = state.dout.oe;
    assign irq_pin_b_o       = state.irq_b.out;
    assign irq_pin_b_oe_o    = state.irq_b.oe;
    // Mode enables to the cores
    assign spi_active_o      = state.spi_mode;                 // RULE1
    assign i2c_active_o      = !state.spi_mode && !i2c_off_i;  // RULE1
    assign i3c_active_o      = !state.spi_mode && !i3c_off_i;  // RULE1
    // Shared serial clock and data
    assign serial_clock_o    = pad_sync_q.scl;       // RULE6
    assign serial_data_o     = pad_sync_q.sda;       // RULE7
    assign addr_lsb_o        = pad_sync_q.addr_lsb;
    // First irq pad sensed; host keeps it low at power-on
    assign irq_a_o           = pad_sync_q.irq_a;     // RULE8
    // Second irq pad inputs by role
    assign data_enable_in_o     = (state.role == IRQ_B_DATA_EN) && pad_sync_q.irq_b;   // RULE4
    assign hub_master_sync_in_o = (state.role == IRQ_B_HUB_SYNC) && pad_sync_q.irq_b;  // RULE5

    ////////////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!resetn_i);

    select_decode_a: assert property ($past(resetn_i, 3) && $past(select_pin_i, 3) == $past(select_pin_i, 4) // RULE1
        |-> spi_active_o == !$past(select_pin_i, 3))
        else $error("SPI mode does not follow select pin");

    select_pullup_a: assert property (i2c_off_i && i3c_off_i |-> !pad_pull_o.select_pullup) // RULE2
        else $error("Select pull-up on while both disabled");

    irq_b_ground_a: assert property (state.role == IRQ_B_GROUND |-> irq_pin_b_oe_o && !irq_pin_b_o) // RULE3
        else $error("Second irq pad not grounded");

    irq_b_output_a: assert property (irq_b_role_i == IRQ_B_OUTPUT [*2] // RULE4
        |=> irq_pin_b_oe_o && irq_pin_b_o == $past(irq_b_level_i))
        else $error("Second irq pad not driving interrupt level");

    data_enable_a: assert property (state.role == IRQ_B_DATA_EN // RULE4
        |-> !irq_pin_b_oe_o && data_enable_in_o == pad_sync_q.irq_b && !hub_master_sync_in_o)
        else $error("Data enable input routing wrong");

    hub_sync_a: assert property (state.role == IRQ_B_HUB_SYNC |-> $past(hub_mode_i)) // RULE5
        else $error("Hub sync role outside hub mode");

    clock_route_a: assert property ($past(resetn_i, 2) |-> serial_clock_o == $past(scl_pin_i, 2)) // RULE6
        else $error("Serial clock not two cycles behind pad");

    sda_four_wire_a: assert property (spi_active_o && !$past(spi_three_wire_i) |-> !sda_pin_oe_o) // RULE7
        else $error("Serial data pad driven in four-wire SPI");

    sda_open_drain_a: assert property (!spi_active_o |-> !sda_pin_o && !addr_lsb_pin_oe_o) // RULE7
        else $error("Serial data not open drain in I2C/I3C");

    pull_follow_a: assert property (pad_pull_o.dout_pullup == dout_pullup_on_i // RULE9 RULE10 RULE11 RULE12
        && pad_pull_o.irq_a_pulldown != irq_a_pulldown_off_i && pad_pull_o.hub_pullup == hub_pullup_on_i)
        else $error("Pad pull does not follow control bits");

    irq_output_c: cover property (state.role == IRQ_B_OUTPUT && irq_pin_b_o);
    three_wire_c: cover property (spi_active_o && sda_pin_oe_o);
    hub_sync_c:   cover property (hub_master_sync_in_o);
    i2c_drive_c:  cover property (i2c_active_o && sda_pin_oe_o);

endmodule : host_pad_mode

// *** verif/host_side_model.sv ***
// Host side of the pads: select, serial lines and interrupt lines as the wire sees them
module host_side_model (
    // Power-on and host levels
    input  wire logic resetn_i,
    input  wire logic sel_i,
    input  wire logic scl_i,
    input  wire logic sda_i,
    input  wire logic den_i,
    input  wire logic irq_a_i,
    // Device pad drives
    input  wire logic sda_out_i,
    input  wire logic sda_oe_i,
    input  wire logic addr_out_i,
    input  wire logic addr_oe_i,
    input  wire logic irqb_out_i,
    input  wire logic irqb_oe_i,
    // Resolved pad levels
    output logic      select_pin_o,
    output logic      scl_pin_o,
    output logic      sda_pin_o,
    output logic      addr_pin_o,
    output logic      irq_a_pin_o,
    output logic      irq_b_pin_o
);
    timeunit 1ns;
    timeprecision 100ps;
    ////////////////////////////////////////////////////////////////////////////
    // Wire levels: the driving party wins, the host strap holds the address low
    always_comb begin
        select_pin_o = sel_i;
        scl_pin_o    = scl_i;
        sda_pin_o    = sda_oe_i ? sda_out_i : sda_i;
        addr_pin_o   = addr_oe_i ? addr_out_i : 1'h0;
        irq_a_pin_o  = resetn_i ? irq_a_i : 1'h0;
        irq_b_pin_o  = irqb_oe_i ? irqb_out_i : den_i;
    end
endmodule : host_side_model

// *** verif/host_pad_mode_bench.sv ***
// Self-checking bench for the host pad mode selector
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin fails++; \
    $display("ERROR %0t: got %h expected %h", $time, (got), (exp)); end end
module host_pad_mode_bench;
    timeunit 1ns;
    timeprecision 100ps;
    import pad_mode_pkg::*;
    typedef struct packed {
        logic [14:0] cfg;  // Select, offs, pulls, hub, 3wire, role, level, den, dout, en, sda low
        logic [14:0] exp;  // Pulls, actives, masked pad drives, den, sync
    } row_s;
    logic        clk_sys = 1'h0;  // 20 MHz clock
    logic        resetn  = 1'h0;  // Active low reset
    logic        sel, i2c_off, i3c_off, dout_pu, pd_off, hub_pu, hub_mode, three_wire;
    logic [1:0]  role;
    logic        lvl, data_enable_in, dout, dout_en, sda_low, host_scl, host_sda, irq_a_lvl;
    wire         select_pin, scl_pin, sda_pin, addr_pin, irq_a_pin, irq_b_pin;
    logic        sda_out, sda_oe, addr_out, addr_oe, irqb_out, irqb_oe;
    logic        spi_act, i2c_act, i3c_act, ser_clk, ser_dat, irq_a, den_in, hub_sync;
    logic        addr_lsb;  // Address LSB pad as sensed by the device
    pad_pull_s   pull;
    int          fails = 0;
    int          n_compared = 0;
    row_s        rows [5] = '{'{15'h4001, 15'h5388}, '{15'h3EB6, 15'h2CCC}, '{15'h6048, 15'h5102},
                              '{15'h5168, 15'h5201}, '{15'h0076, 15'h5438}};
    ////////////////////////////////////////////////////////////////////////////
    // Clock
    always #25 clk_sys = ~clk_sys;
    ////////////////////////////////////////////////////////////////////////////
    // Device and host
    host_pad_mode u_host_pad_mode (.clk_sys_i(clk_sys), .resetn_i(resetn), .select_pin_i(select_pin),
        .scl_pin_i(scl_pin), .sda_pin_i(sda_pin), .sda_pin_o(sda_out), .sda_pin_oe_o(sda_oe),
        .addr_lsb_pin_i(addr_pin), .addr_lsb_pin_o(addr_out), .addr_lsb_pin_oe_o(addr_oe),
        .irq_pin_a_i(irq_a_pin), .irq_pin_b_i(irq_b_pin), .irq_pin_b_o(irqb_out), .irq_pin_b_oe_o(irqb_oe),
        .pad_pull_o(pull), .i2c_off_i(i2c_off), .i3c_off_i(i3c_off), .dout_pullup_on_i(dout_pu),
        .irq_a_pulldown_off_i(pd_off), .hub_pullup_on_i(hub_pu), .hub_mode_i(hub_mode),
        .spi_three_wire_i(three_wire), .irq_b_role_i(irq_b_role_e'(role)), .irq_b_level_i(lvl),
        .spi_dout_i(dout), .spi_dout_en_i(dout_en), .i2c_sda_low_i(sda_low), .spi_active_o(spi_act),
        .i2c_active_o(i2c_act), .i3c_active_o(i3c_act), .serial_clock_o(ser_clk), .serial_data_o(ser_dat),
        .addr_lsb_o(addr_lsb), .irq_a_o(irq_a), .data_enable_in_o(den_in), .hub_master_sync_in_o(hub_sync));
    host_side_model u_host_side_model (.resetn_i(resetn), .sel_i(sel), .scl_i(host_scl),
        .sda_i(host_sda), .den_i(data_enable_in), .irq_a_i(irq_a_lvl), .sda_out_i(sda_out), .sda_oe_i(sda_oe),
        .addr_out_i(addr_out), .addr_oe_i(addr_oe), .irqb_out_i(irqb_out), .irqb_oe_i(irqb_oe),
        .select_pin_o(select_pin), .scl_pin_o(scl_pin), .sda_pin_o(sda_pin), .addr_pin_o(addr_pin),
        .irq_a_pin_o(irq_a_pin), .irq_b_pin_o(irq_b_pin));
    ////////////////////////////////////////////////////////////////////////////
    // Helpers
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys);
        #5;
    endtask : step
    task automatic drive(input logic [14:0] cfg);
        {sel, i2c_off, i3c_off, dout_pu, pd_off, hub_pu, hub_mode, three_wire, role, lvl, data_enable_in, dout,
         dout_en, sda_low} = cfg;
    endtask : drive
    // Verdict and end of run
    task automatic wrap_up;
        $display("Compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : wrap_up
    ////////////////////////////////////////////////////////////////////////////
    // Watchdog, far beyond the few dozen cycles the run needs
    initial begin
        #200000;
        fails++;
        wrap_up();
    end
    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        drive(15'h4000);
        {host_scl, host_sda, irq_a_lvl} = 3'h0;
        step(4);
        `CHK({irqb_oe, irqb_out, spi_act}, 3'h4)
        step(1);
        resetn = 1'h1;
        // Table of steady configurations
        foreach (rows[i]) begin
            drive(rows[i].cfg);
            step(5);
            `CHK({pull, spi_act, i2c_act, i3c_act, sda_oe, sda_oe & sda_out, addr_oe, addr_oe & addr_out,
                  irqb_oe, irqb_oe & irqb_out, den_in, hub_sync}, rows[i].exp)
            `CHK(addr_lsb, rows[i].exp[4])
        end
        // Pull enables settle before any clock edge
        drive(15'h7E00);
        #1;
        `CHK(pull, pad_pull_s'(4'h5))
        // Serial pads pass through with the device released
        drive(15'h4000);
        for (int k = 0; k < 2; k++) begin
            {host_scl, host_sda, irq_a_lvl} = {k[0], ~k[0], k[0]};
            step(3);
            `CHK({ser_clk, ser_dat, irq_a}, {k[0], ~k[0], k[0]})
        end
        // Mid-run reset forces the second interrupt pad back to ground
        drive(15'h4030);
        step(2);
        `CHK({irqb_oe, irqb_out}, 2'h3)
        resetn = 1'h0;
        #1;
        `CHK({irqb_oe, irqb_out, spi_act}, 3'h4)
        step(2);
        resetn = 1'h1;
        step(1);
        `CHK({irqb_oe, irqb_out, spi_act}, 3'h6)
        step(2);
        wrap_up();
    end
endmodule : host_pad_mode_bench
